//--- core/btr_pkg.sv
// package of constants for the branch trace recorder
// Summary of operation
// - while recording enable (bit 0) is set, capture from/to of branches, interrupts, exceptions
// - any debug exception clears recording enable
// - branch step bit (bit 1) makes single step act on taken transfers only
// - branch step plus trap flag raise a single-step debug exception on next transfer
// - any debug exception clears branch step bit and trap single-step flag
// - set pin select bit (bits 2-5) pulses its breakpoint pin on address match
// - clear pin select bit routes performance events to that pin instead
// - trace message enable (bit 6) sends to/from addresses on the system bus
// - record registers may be undefined while trace messages are enabled
// - trace from address is next instruction, or the branch itself when it faults
// - taken branch loads branch address into source, destination into target record
// - interrupt or exception loads interrupted address and handler address
// - interrupt or exception first copies source/target records into prior records
// - each of the four address records holds 32 bits
// - debug exceptions are not recorded and leave all records unchanged
// - addresses are code segment offsets, not linear addresses
// - control writes accepted only at privilege level 0 or real-address mode
// - the four record registers are readable by the register read instruction
package btr_pkg;
	localparam int ip_width = 32;
	localparam int ctl_width = 7;
	localparam int pins = 4;
	// ----------------------------------------
	// register indices
	// ----------------------------------------
	localparam logic [2:0] reg_debug_control = 3'h0;
	localparam logic [2:0] reg_branch_source = 3'h1;
	localparam logic [2:0] reg_branch_target = 3'h2;
	localparam logic [2:0] reg_prior_source = 3'h3;
	localparam logic [2:0] reg_prior_target = 3'h4;
	// ----------------------------------------
	// control fields
	// ----------------------------------------
	localparam int bit_record = 0;
	localparam int bit_branch_step = 1;
	localparam int bit_pin_lo = 2;
	localparam int bit_trace = 6;
	localparam logic [6:0] ctl_reset = 7'h00;
endpackage

//--- core/btr_recorder.sv
// branch trace recorder core logic
`timescale 1ns/100ps
module btr_recorder #(
	parameter int ip_w = 32
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic reg_write,
	input wire logic [2:0] reg_index,
	input wire logic [ip_w-1:0] reg_wdata,
	input wire logic write_privileged,
	output logic [ip_w-1:0] reg_rdata,
	input wire logic branch_taken,
	input wire logic branch_faulted,
	input wire logic [ip_w-1:0] branch_ip,
	input wire logic [ip_w-1:0] next_ip,
	input wire logic [ip_w-1:0] dest_ip,
	input wire logic intr_taken,
	input wire logic [ip_w-1:0] interrupted_ip,
	input wire logic [ip_w-1:0] handler_ip,
	input wire logic debug_exception,
	input wire logic trap_flag_in,
	input wire logic trap_flag_set,
	output logic trap_single_step_flag,
	output logic step_trap,
	input wire logic [3:0] bp_match,
	input wire logic [3:0] perf_event,
	output logic [3:0] bp_pin_n,
	output logic trace_valid,
	output logic [ip_w-1:0] trace_from,
	output logic [ip_w-1:0] trace_to
);
	initial begin
		if (ip_w != btr_pkg::ip_width) $error("ip_w must be 32");
	end
	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic [6:0] ctl_q, ctl_d;
	logic tf_q, tf_d;
	logic [ip_w-1:0] src_q, tgt_q, psrc_q, ptgt_q;
	logic [3:0] pin_q;
	logic tv_q;
	logic [ip_w-1:0] tfrom_q, tto_q;
	wire ctl_wr = reg_write && write_privileged && reg_index == btr_pkg::reg_debug_control;
	wire rec_en = ctl_q[btr_pkg::bit_record];
	wire step_en = ctl_q[btr_pkg::bit_branch_step];
	wire trace_en = ctl_q[btr_pkg::bit_trace];
	wire xfer = branch_taken || intr_taken;
	// debug exceptions win over any transfer in the same cycle
	wire rec_branch = rec_en && branch_taken && !intr_taken && !debug_exception;
	wire rec_intr = rec_en && intr_taken && !debug_exception;
	assign step_trap = step_en && tf_q && xfer && !debug_exception;
	assign trap_single_step_flag = tf_q;
	assign bp_pin_n = ~pin_q;
	assign trace_valid = tv_q;
	assign trace_from = tfrom_q;
	assign trace_to = tto_q;
	assign reg_rdata = reg_index == btr_pkg::reg_debug_control ? {{(ip_w-7){1'b0}}, ctl_q} :
		reg_index == btr_pkg::reg_branch_source ? src_q :
		reg_index == btr_pkg::reg_branch_target ? tgt_q :
		reg_index == btr_pkg::reg_prior_source ? psrc_q :
		reg_index == btr_pkg::reg_prior_target ? ptgt_q : '0;
	always_comb begin
		ctl_d = ctl_wr ? reg_wdata[6:0] : ctl_q;
		tf_d = trap_flag_set ? trap_flag_in : tf_q;
		if (debug_exception) begin
			ctl_d[btr_pkg::bit_record] = 1'b0;
			ctl_d[btr_pkg::bit_branch_step] = 1'b0;
			tf_d = 1'b0;
		end
	end
	// ----------------------------------------
	// state
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			ctl_q <= btr_pkg::ctl_reset;
			tf_q <= 1'b0;
		end else begin
			ctl_q <= ctl_d;
			tf_q <= tf_d;
		end
	end
	// records hold code segment offsets as given by the core; ignored: records kept valid
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			src_q <= '0;
			tgt_q <= '0;
			psrc_q <= '0;
			ptgt_q <= '0;
		end else if (rec_intr) begin
			psrc_q <= src_q;
			ptgt_q <= tgt_q;
			src_q <= interrupted_ip;
			tgt_q <= handler_ip;
		end else if (rec_branch) begin
			src_q <= branch_ip;
			tgt_q <= dest_ip;
		end
	end
	// pin is active low one cycle after each cycle of its selected match or event
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_pin
			always_ff @(posedge clk) begin
				if (!reset_n) pin_q[i] <= 1'b0;
				else pin_q[i] <= ctl_q[btr_pkg::bit_pin_lo+i] ? bp_match[i] : perf_event[i];
			end
		end
	endgenerate
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			tv_q <= 1'b0;
			tfrom_q <= '0;
			tto_q <= '0;
		end else begin
			tv_q <= trace_en && xfer && !debug_exception;
			if (trace_en && xfer) begin
				tfrom_q <= intr_taken ? interrupted_ip : (branch_faulted ? branch_ip : next_ip);
				tto_q <= intr_taken ? handler_ip : dest_ip;
			end
		end
	end
endmodule

//--- testbench/btr_recorder_asserts.sv
// assertions for the branch trace recorder
`timescale 1ns/100ps
module btr_recorder_asserts #(parameter int ip_w = 32) (
	input wire logic clk, reset_n, branch_taken, branch_faulted, intr_taken, debug_exception,
	input wire logic trap_single_step_flag, step_trap, trace_valid,
	input wire logic [3:0] bp_match, perf_event, bp_pin_n,
	input wire logic [ip_w-1:0] branch_ip, next_ip, dest_ip, trace_from, trace_to
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence s_br;
		branch_taken && !intr_taken && !debug_exception;
	endsequence
	a_trace_from: assert property (s_br ##1 trace_valid |-> trace_from == $past(branch_faulted ? branch_ip : next_ip))
		else $error("trace from address wrong");
	a_trace_to: assert property (s_br ##1 trace_valid |-> trace_to == $past(dest_ip)) else $error("trace to wrong");
	a_trace_cause: assert property (trace_valid |-> $past(branch_taken || intr_taken) && !$past(debug_exception))
		else $error("trace without event");
	a_step_cause: assert property (step_trap |-> (branch_taken || intr_taken) && trap_single_step_flag)
		else $error("step trap without cause");
	a_step_clear: assert property (debug_exception |=> !step_trap && !trap_single_step_flag)
		else $error("step state kept");
	a_pins_idle: assert property (!(|bp_match) && !(|perf_event) |=> bp_pin_n == 4'hf) else $error("pin low");
	a_pin_pulse: assert property (bp_match[0] && perf_event[0] |=> !bp_pin_n[0]) else $error("pin not pulsed");
	a_pin_cause: assert property (!bp_pin_n[1] |-> $past(bp_match[1] || perf_event[1]))
		else $error("pin low without cause");
endmodule
bind btr_recorder btr_recorder_asserts #(.ip_w(ip_w)) chk (.*);

//--- testbench/btr_trace_monitor.sv
// system bus trace message monitor
`timescale 1ns/100ps
module btr_trace_monitor (
	input wire logic clk, trace_valid,
	input wire logic [31:0] trace_from, trace_to,
	output logic [31:0] mon_from, mon_to
);
	always @(posedge clk) if (trace_valid) begin
		mon_from <= trace_from;
		mon_to <= trace_to;
	end
endmodule

//--- testbench/btr_recorder_tb.sv
// testbench for the branch trace recorder
`timescale 1ns/100ps
module btr_recorder_tb;
	logic clk = 0, reset_n = 0, reg_write = 0, write_privileged = 0, branch_taken = 0, branch_faulted = 0;
	logic intr_taken = 0, debug_exception = 0, trap_flag_in = 0, trap_flag_set = 0;
	logic [2:0] reg_index = 3'h0;
	logic [31:0] reg_wdata = 0, reg_rdata, trace_from, trace_to, mon_from, mon_to;
	logic [31:0] branch_ip = 32'h100, next_ip = 32'h104, dest_ip = 32'h200, interrupted_ip = 32'h300;
	logic [31:0] handler_ip = 32'h400;
	logic [3:0] bp_match = 0, perf_event = 0, bp_pin_n;
	logic trap_single_step_flag, step_trap, trace_valid;
	int failures = 0, num_checks = 0;
	btr_recorder DUT (.*);
	btr_trace_monitor mon (.*);
	always #20 clk = ~clk;
	task tick; @(negedge clk); endtask
	task chk(input string n, input logic [31:0] s, e);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task wr(input logic [2:0] i, input logic [31:0] d, input logic p);
		reg_write = 1; reg_index = i; reg_wdata = d; write_privileged = p;
		tick;
		reg_write = 0;
	endtask
	task rd(input logic [2:0] i, input logic [31:0] e);
		reg_index = i;
		#1 chk("register", reg_rdata, e);
	endtask
	task stop_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	initial begin
		#100us failures++;
		stop_test;
	end
	initial begin
		repeat (8) tick;
		reset_n = 1;
		rd(0, 0);
		wr(0, 1, 0); rd(0, 0);
		wr(0, 1, 1); branch_taken = 1; tick; branch_taken = 0;
		rd(1, 32'h100); rd(2, 32'h200);
		intr_taken = 1; tick; intr_taken = 0;
		rd(3, 32'h100); rd(4, 32'h200); rd(1, 32'h300); rd(2, 32'h400);
		wr(1, 0, 1); rd(1, 32'h300);
		debug_exception = 1; tick; debug_exception = 0;
		rd(0, 0); rd(2, 32'h400);
		wr(0, 32'h43, 1); trap_flag_set = 1; trap_flag_in = 1; tick; trap_flag_set = 0;
		branch_taken = 1; #1 chk("step", step_trap, 1);
		tick; branch_taken = 0; tick;
		chk("from", mon_from, 32'h104); chk("to", mon_to, 32'h200);
		debug_exception = 1; tick; debug_exception = 0;
		rd(0, 32'h40); chk("flag", trap_single_step_flag, 0);
		wr(0, 32'h14, 1); bp_match = 4'hf; perf_event = 4'h3; tick;
		bp_match = 0; perf_event = 4'hf; chk("pins", bp_pin_n, 4'h8); tick;
		perf_event = 0; chk("pins", bp_pin_n, 4'h5);
		wr(0, 32'h41, 1); branch_taken = 1; branch_faulted = 1; tick; branch_taken = 0; branch_faulted = 0; tick;
		chk("from", mon_from, 32'h100); chk("to", mon_to, 32'h200);
		intr_taken = 1; tick; intr_taken = 0; tick;
		chk("from", mon_from, 32'h300); chk("to", mon_to, 32'h400);
		debug_exception = 1; branch_taken = 1; tick; debug_exception = 0; branch_taken = 0;
		chk("trace", trace_valid, 0);
		rd(1, 32'h300); rd(2, 32'h400); rd(3, 32'h100);
		rd(5, 0);
		tick;
		stop_test;
	end
endmodule
